// file: rtl/pisl_pkg.sv
package pisl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] PISL_ADDR_SYS = 8'h1a;
  localparam logic [7:0] PISL_ADDR_UV = 8'h1c;
  localparam logic [7:0] PISL_ADDR_OC = 8'h1d;
  localparam logic [7:0] PISL_ADDR_PIN = 8'h1e;
  localparam logic [7:0] PISL_ADDR_MASK = 8'h20;

  localparam logic [15:0] PISL_STATUS_RESET = 16'h0000;
  localparam logic [15:0] PISL_READ_ZERO = 16'h0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PISL_SYS_SUPPLY_BIT = 3;
  localparam int PISL_SYS_TEMP115_BIT = 2;
  localparam int PISL_SYS_TEMP140_BIT = 1;
  localparam int PISL_SYS_WDOG_BIT = 0;
  localparam int PISL_SYS_W = 4;
  localparam int PISL_UV_LDO_LSB = 8;
  localparam int PISL_UV_LDO_W = 4;
  localparam int PISL_UV_DC_LSB = 0;
  localparam int PISL_UV_DC_W = 6;
  localparam int PISL_OC_LS_BIT = 15;
  localparam int PISL_PIN_W = 13;

  // Mask bits and their reset value
  localparam int PISL_MASK_OC_BIT = 13;
  localparam int PISL_MASK_UV_BIT = 12;
  localparam int PISL_MASK_PIN_BIT = 6;
  localparam int PISL_MASK_SYS_BIT = 0;
  localparam logic [15:0] PISL_MASK_RESET = 16'h3041;
  localparam logic [15:0] PISL_MASK_USED = 16'h3041;

  // Fixed-trigger sources: 4 system, 6 converters, 4 linear regulators, 1 switch
  localparam int PISL_FIX_W = 15;

endpackage

// file: rtl/pisl_status_latches.sv
`timescale 1ns/1ps
// Summary of operation
// - Supply below shutdown threshold sets system status bit 3.
// - Die temperature above 115 degrees sets system status bit 2.
// - Die temperature above 140 degrees sets bit 1, independent of bit 2.
// - Watchdog expiry sets system status bit 0.
// - Linear regulators four to one flag under-voltage in bits 11 to 8.
// - Converters six to one flag under-voltage in bits 5 to 0.
// - Limit-switch overcurrent rising edge sets overcurrent status bit 15.
// - Thirteen pin event flags in bits 12 to 0, trigger chosen per pin.
// - Fixed flags set only on rising source edges, never by steady level.
// - Flags hold until their word is read; the read clears them.
// - Group mask bits reset to one; zero lets group drive interrupt.
module pisl_status_latches
  import pisl_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Analog fault sources, asynchronous levels
  input wire logic supply_low_in,
  input wire logic temp_over115_in,
  input wire logic temp_over140_in,
  input wire logic watchdog_expired_in,
  input wire logic [PISL_UV_LDO_W-1:0] linear_reg_low_in,
  input wire logic [PISL_UV_DC_W-1:0] converter_low_in,
  input wire logic limit_switch_oc_in,
  // Per-pin triggers from edge selection logic, same clock
  input wire logic [PISL_PIN_W-1:0] pin_trigger_in,
  // Interrupt
  output logic irq_out
);

  // ****************************************
  // Source synchronisers and edge detect
  // ****************************************
  logic [PISL_FIX_W-1:0] src_raw;
  logic [PISL_FIX_W-1:0] sync1_reg;
  logic [PISL_FIX_W-1:0] sync2_reg;
  logic [PISL_FIX_W-1:0] prev_reg;
  logic [PISL_FIX_W-1:0] rise;

  assign src_raw = {limit_switch_oc_in, linear_reg_low_in, converter_low_in,
                    supply_low_in, temp_over115_in, temp_over140_in,
                    watchdog_expired_in};

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= src_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Steady level after a clear cannot set again
  assign rise = sync2_reg & ~prev_reg;

  // ****************************************
  // Read decode and clear strobes
  // ****************************************
  logic rd_sys;
  logic rd_uv;
  logic rd_oc;
  logic rd_pin;

  assign rd_sys = reg_rd_in && (reg_addr_in == PISL_ADDR_SYS);
  assign rd_uv = reg_rd_in && (reg_addr_in == PISL_ADDR_UV);
  assign rd_oc = reg_rd_in && (reg_addr_in == PISL_ADDR_OC);
  assign rd_pin = reg_rd_in && (reg_addr_in == PISL_ADDR_PIN);

  // ****************************************
  // Flag latches
  // ****************************************
  logic [PISL_SYS_W-1:0] sys_flag_reg;
  logic [PISL_SYS_W-1:0] sys_flag_next;
  logic [PISL_UV_LDO_W-1:0] ldo_flag_reg;
  logic [PISL_UV_LDO_W-1:0] ldo_flag_next;
  logic [PISL_UV_DC_W-1:0] dc_flag_reg;
  logic [PISL_UV_DC_W-1:0] dc_flag_next;
  logic oc_flag_reg;
  logic oc_flag_next;
  logic [PISL_PIN_W-1:0] pin_flag_reg;
  logic [PISL_PIN_W-1:0] pin_flag_next;
  logic [PISL_SYS_W-1:0] sys_rise;
  logic [PISL_UV_DC_W-1:0] dc_rise;
  logic [PISL_UV_LDO_W-1:0] ldo_rise;

  // Source order: watchdog, 140, 115, supply, converters, regulators, switch
  assign sys_rise = rise[PISL_SYS_W-1:0];
  assign dc_rise = rise[PISL_SYS_W +: PISL_UV_DC_W];
  assign ldo_rise = rise[PISL_SYS_W+PISL_UV_DC_W +: PISL_UV_LDO_W];

  // Set wins over the clearing read so no event is lost
  assign sys_flag_next = (sys_flag_reg & {PISL_SYS_W{~rd_sys}}) | sys_rise;
  assign ldo_flag_next = (ldo_flag_reg & {PISL_UV_LDO_W{~rd_uv}}) | ldo_rise;
  assign dc_flag_next = (dc_flag_reg & {PISL_UV_DC_W{~rd_uv}}) | dc_rise;
  assign oc_flag_next = (oc_flag_reg & ~rd_oc) | rise[PISL_FIX_W-1];
  assign pin_flag_next = (pin_flag_reg & {PISL_PIN_W{~rd_pin}}) | pin_trigger_in;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sys_flag_reg <= '0;
      ldo_flag_reg <= '0;
      dc_flag_reg <= '0;
      oc_flag_reg <= 1'b0;
      pin_flag_reg <= '0;
    end else begin
      sys_flag_reg <= sys_flag_next;
      ldo_flag_reg <= ldo_flag_next;
      dc_flag_reg <= dc_flag_next;
      oc_flag_reg <= oc_flag_next;
      pin_flag_reg <= pin_flag_next;
    end
  end

  // ****************************************
  // Status words
  // ****************************************
  logic [15:0] sys_word;
  logic [15:0] uv_word;
  logic [15:0] oc_word;
  logic [15:0] pin_word;

  always_comb begin
    sys_word = PISL_STATUS_RESET;
    uv_word = PISL_STATUS_RESET;
    oc_word = PISL_STATUS_RESET;
    pin_word = PISL_STATUS_RESET;
    sys_word[PISL_SYS_SUPPLY_BIT] = sys_flag_reg[3];
    sys_word[PISL_SYS_TEMP115_BIT] = sys_flag_reg[2];
    sys_word[PISL_SYS_TEMP140_BIT] = sys_flag_reg[1];
    sys_word[PISL_SYS_WDOG_BIT] = sys_flag_reg[0];
    uv_word[PISL_UV_LDO_LSB +: PISL_UV_LDO_W] = ldo_flag_reg;
    uv_word[PISL_UV_DC_LSB +: PISL_UV_DC_W] = dc_flag_reg;
    oc_word[PISL_OC_LS_BIT] = oc_flag_reg;
    pin_word[PISL_PIN_W-1:0] = pin_flag_reg;
  end

  // ****************************************
  // Mask register
  // ****************************************
  logic [15:0] mask_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mask_reg <= PISL_MASK_RESET;
    end else if (reg_wr_in && (reg_addr_in == PISL_ADDR_MASK)) begin
      mask_reg <= reg_wdata_in & PISL_MASK_USED;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= PISL_READ_ZERO;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          PISL_ADDR_SYS: reg_rdata_out <= sys_word;
          PISL_ADDR_UV: reg_rdata_out <= uv_word;
          PISL_ADDR_OC: reg_rdata_out <= oc_word;
          PISL_ADDR_PIN: reg_rdata_out <= pin_word;
          PISL_ADDR_MASK: reg_rdata_out <= mask_reg;
          // Unmapped addresses read as zero
          default: reg_rdata_out <= PISL_READ_ZERO;
        endcase
      end
    end
  end

  // ****************************************
  // Interrupt output
  // ****************************************
  logic irq_next;

  assign irq_next = ((|sys_flag_next) && !mask_reg[PISL_MASK_SYS_BIT]) ||
                    ((|{ldo_flag_next, dc_flag_next}) && !mask_reg[PISL_MASK_UV_BIT]) ||
                    (oc_flag_next && !mask_reg[PISL_MASK_OC_BIT]) ||
                    ((|pin_flag_next) && !mask_reg[PISL_MASK_PIN_BIT]);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_next;
    end
  end

endmodule

// file: verif/pisl_status_latches_properties.sv
`timescale 1ns/1ps
module pisl_chk
  import pisl_pkg::*;
(
  // Watched ports
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic limit_switch_oc_in,
  input wire logic [12:0] pin_trigger_in,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence rd_pin;
    reg_rd_in && reg_addr_in == PISL_ADDR_PIN && pin_trigger_in == 13'h0000;
  endsequence
  sequence rd_oc;
    reg_rd_in && reg_addr_in == PISL_ADDR_OC && limit_switch_oc_in;
  endsequence
  a_ans_pulse: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("missing answer");
  a_no_stray: assert property (!reg_rd_in |=> !reg_rvalid_out && $stable(reg_rdata_out))
    else $error("stray answer");
  a_gap_zero: assert property (reg_rd_in && reg_addr_in == 8'h1b |=> !reg_rdata_out)
    else $error("hole not zero");
  a_reread_clear: assert property (rd_pin ##1 rd_pin |=> !reg_rdata_out)
    else $error("flags not cleared");
  a_pin_kept: assert property (pin_trigger_in != 13'h0000 ##1 rd_pin |=>
    (reg_rdata_out[12:0] & $past(pin_trigger_in, 2)) == $past(pin_trigger_in, 2))
    else $error("pin event lost");
  a_oc_steady: assert property (limit_switch_oc_in [*4] ##1 rd_oc ##1 rd_oc |=>
    !reg_rdata_out) else $error("level set flag again");
  a_reset_quiet: assert property ($past(srst_in) |-> !irq_out && !reg_rvalid_out)
    else $error("busy after reset");
  a_mask_quiet: assert property (reg_wr_in && reg_addr_in == PISL_ADDR_MASK &&
    (reg_wdata_in & PISL_MASK_USED) == PISL_MASK_USED ##1 !reg_wr_in |=> !irq_out)
    else $error("masked irq high");
endmodule
bind pisl_status_latches pisl_chk u_chk (.clk_in(clk_in), .srst_in(srst_in),
  .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .limit_switch_oc_in(limit_switch_oc_in),
  .pin_trigger_in(pin_trigger_in), .irq_out(irq_out));

// file: verif/pisl_host_model.sv
`timescale 1ns/1ps
module pisl_host_model
  import pisl_pkg::*;
(
  // Register port
  input wire logic clk_in,
  output logic [7:0] reg_addr_out,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output logic [15:0] reg_wdata_out,
  input wire logic [15:0] reg_rdata_in
);
  initial begin
    reg_addr_out = 8'hff;
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_wdata_out = 16'h0000;
  end
  // Two back-to-back reads; both kept since the first one clears
  task automatic rd2(input logic [7:0] a, output logic [15:0] f, output logic [15:0] s);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge clk_in);
    f = reg_rdata_in;
    @(negedge clk_in);
    reg_rd_out = 1'b0;
    s = reg_rdata_in;
    reg_addr_out = ~a;
  endtask
  task automatic wr(input logic [15:0] d);
    @(negedge clk_in);
    reg_addr_out = PISL_ADDR_MASK;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clk_in);
    reg_wr_out = 1'b0;
    reg_addr_out = 8'hff;
  endtask
endmodule

// file: verif/tb_pmic_interrupt_status_latches.sv
`timescale 1ns/1ps
module tb_pmic_interrupt_status_latches;
  import pisl_pkg::*;
  logic clk_in, srst_in, rd, wr, irq;
  logic [7:0] addr;
  logic [15:0] wd, rdata, f, s;
  logic [14:0] src;
  logic [12:0] pin;
  int bad_count, n_tests;
  pisl_status_latches DUT (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr),
    .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rdata),
    .reg_rvalid_out(), .supply_low_in(src[3]), .temp_over115_in(src[2]),
    .temp_over140_in(src[1]), .watchdog_expired_in(src[0]),
    .linear_reg_low_in(src[13:10]), .converter_low_in(src[9:4]),
    .limit_switch_oc_in(src[14]), .pin_trigger_in(pin), .irq_out(irq));
  pisl_host_model HOST (.clk_in(clk_in), .reg_addr_out(addr), .reg_rd_out(rd),
    .reg_wr_out(wr), .reg_wdata_out(wd), .reg_rdata_in(rdata));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Reset values; 1bh is a hole in the map
  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      HOST.rd2(i == 4 ? 8'h1b : PISL_ADDR_SYS + 8'(i + (i > 0)), f, s);
      chk(f, PISL_STATUS_RESET);
      chk(s, PISL_STATUS_RESET);
    end
    HOST.rd2(PISL_ADDR_MASK, f, s);
    chk(s, PISL_MASK_RESET);
  endtask
  // Each fixed source alone, then held high across a clear
  task automatic t_fixed;
    logic [7:0] a;
    logic [15:0] e;
    for (int i = 0; i < 15; i++) begin
      a = i < 4 ? PISL_ADDR_SYS : (i < 14 ? PISL_ADDR_UV : PISL_ADDR_OC);
      e = 16'h0001 << (i < 4 ? i : (i < 10 ? i - 4 : (i < 14 ? i - 2 : 15)));
      @(negedge clk_in);
      src = 15'h0001 << i;
      repeat (4) @(negedge clk_in);
      HOST.rd2(a, f, s);
      chk(f, e);
      chk(s, 16'h0000);
      repeat (3) @(negedge clk_in);
      HOST.rd2(a, f, s);
      chk(f, 16'h0000);
      src = 15'h0000;
    end
  endtask
  // Pin pulse lands in the cycle of a clearing read
  task automatic t_pin;
    fork
      HOST.rd2(PISL_ADDR_PIN, f, s);
      begin
        @(negedge clk_in);
        pin = 13'h1fff;
        @(negedge clk_in);
        pin = 13'h0000;
      end
    join
    chk(s, 16'h1fff);
  endtask
  task automatic t_irq;
    HOST.wr(16'h0000);
    @(negedge clk_in);
    pin = 13'h0001;
    @(negedge clk_in);
    pin = 13'h0000;
    chk({15'h0000, irq}, 16'h0001);
    HOST.rd2(PISL_ADDR_PIN, f, s);
    chk({15'h0000, irq}, 16'h0000);
    // System, under-voltage and overcurrent groups each unmasked alone
    for (int g = 0; g < 3; g++) begin
      HOST.wr(g == 0 ? 16'h3040 : (g == 1 ? 16'h2041 : 16'h1041));
      src = 15'h0001 << (g == 0 ? 0 : (g == 1 ? 4 : 14));
      repeat (4) @(negedge clk_in);
      chk({15'h0000, irq}, 16'h0001);
      HOST.rd2(g == 0 ? PISL_ADDR_SYS : (g == 1 ? PISL_ADDR_UV : PISL_ADDR_OC), f, s);
      src = 15'h0000;
      chk({15'h0000, irq}, 16'h0000);
    end
    HOST.wr(16'hffff);
    HOST.rd2(PISL_ADDR_MASK, f, s);
    chk(f, PISL_MASK_USED);
  endtask
  initial begin
    srst_in = 1'b1;
    src = 15'h0000;
    pin = 13'h0000;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    t_reset();
    t_fixed();
    t_pin();
    t_irq();
    complete_run();
  end
  // Whole run is a few hundred cycles
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule
